// File: tcirq_defines.svh
// Constants for the trap reason and interrupt status CSR block.
`ifndef TCIRQ_DEFINES_SVH
`define TCIRQ_DEFINES_SVH
// CSR addresses of the registers held here.
`define TCIRQ_ADDR_REASON 12'h342
`define TCIRQ_ADDR_PEND 12'h344
`define TCIRQ_ADDR_NEXT 12'h345
`define TCIRQ_ADDR_LVLST 12'h346
`define TCIRQ_ADDR_VBASE 12'h307
// Pending flag positions, equal to their interrupt codes.
`define TCIRQ_PEND_SW 3
`define TCIRQ_PEND_TIMER 7
`define TCIRQ_PEND_EXT 11
// Trap reason field layout.
`define TCIRQ_RSN_IRQ 31
`define TCIRQ_RSN_HWV 30
`define TCIRQ_RSN_PRIV_HI 29
`define TCIRQ_RSN_PRIV_LO 28
`define TCIRQ_RSN_LVL_HI 27
`define TCIRQ_RSN_LVL_LO 24
`define TCIRQ_RSN_PIE 23
`define TCIRQ_RSN_CODE_HI 9
// Level status field and vector base alignment.
`define TCIRQ_LVLST_HI 15
`define TCIRQ_LVLST_LO 12
`define TCIRQ_VBASE_LO 6
// Machine status fields mirrored into the trap reason.
`define TCIRQ_MST_PIE 7
`define TCIRQ_MST_PRIV_HI 12
`define TCIRQ_MST_PRIV_LO 11
// Trap vector modes that select the local controller.
`define TCIRQ_MODE_LDIRECT 2'h2
`define TCIRQ_MODE_LVECTOR 2'h3
// Interrupt and exception code limits.
`define TCIRQ_IRQ_LSW 10'h00c
`define TCIRQ_IRQ_LOCAL_LO 10'h010
`define TCIRQ_IRQ_LOCAL_HI 10'h08f
`define TCIRQ_EXC_UCALL 10'h008
`define TCIRQ_EXC_MCALL 10'h00b
`endif

// File: tcirq_pkg.sv
// Types shared by the trap reason and interrupt status CSR block.
package tcirq_pkg;
  // CSR instruction operation kinds.
  typedef enum logic [1:0] {
    CSR_OP_NONE = 2'b00,
    CSR_OP_WRITE = 2'b01,
    CSR_OP_SET = 2'b10,
    CSR_OP_CLEAR = 2'b11
  } tcirq_op_e;
  // Hardware vectoring sequencer states.
  typedef enum logic [0:0] {
    VEC_IDLE = 1'b0,
    VEC_FETCH = 1'b1
  } tcirq_vec_e;
endpackage

// File: tcirq_rst_sync.sv
// Reset release synchroniser for the CSR block.
`timescale 1ns/1ns
module tcirq_rst_sync (
  // Clock and raw reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Synchronised reset.
  output logic rstSync_n
);
  // Two stages; the first stage is read only by the second.
  logic [1:0] stage_r;

  // Assert at once, release after two edges so no flop sees a ragged release.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r <= 2'h0;
    end else begin
      stage_r <= {stage_r[0], 1'b1};
    end
  end

  assign rstSync_n = stage_r[1];
endmodule

// File: tcirq_csr_rmw.sv
// Read-modify-write merge of a CSR instruction's operand into an old value.
`timescale 1ns/1ns
module tcirq_csr_rmw (
  // Operation and operand.
  input wire tcirq_pkg::tcirq_op_e op,
  input wire logic [31:0] operand,
  // Old and merged values.
  input wire logic [31:0] oldValue,
  output logic [31:0] newValue
);
  // Set and clear touch only the operand's one bits.
  always_comb begin
    unique case (op)
      tcirq_pkg::CSR_OP_WRITE: newValue = operand;
      tcirq_pkg::CSR_OP_SET: newValue = oldValue | operand;
      tcirq_pkg::CSR_OP_CLEAR: newValue = oldValue & ~operand;
      tcirq_pkg::CSR_OP_NONE: newValue = oldValue;
    endcase
  end
endmodule

// File: tcirq_csr.sv
// Trap reason, pending, vector base, next handler and level status CSRs.
`timescale 1ns/1ns
`include "tcirq_defines.svh"

// Functional notes
// - Pending flags at bits 3, 7, 11.
// - Pending reads zero in local-controller modes.
// - Trap taken writes its cause into reason.
// - Interrupt trap sets bit 31, interrupt number.
// - Exception trap clears bit 31, exception code.
// - Cause code bits 9:0, 22:10 reserved.
// - Local mode adds enable, level, privilege fields.
// - Bit 30 set while hardware vectoring runs.
// - Interrupt codes 3, 7, 11, 12, 16-143.
// - Exception codes 0-8 and 11 only.
// - Vector base in bits 31:6, aligned.
// - Next handler reads zero or table entry.
// - Offer only levels above saved level.
// - Writing next handler modifies machine status, level.
// - Pure read of next handler changes nothing.
// - Next handler returns pointer, not merged value.
// - Level status shows active level, bits 15:12.
// - Vectored fetch at base plus four codes.
// - Fetched address low bit cleared; flag clears in the same cycle.
// - Modes 2 and 3 select local controller.
module tcirq_csr (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // CSR instruction port.
  input wire logic csrValid,
  input wire logic [11:0] csrAddr,
  input wire tcirq_pkg::tcirq_op_e csrOp,
  input wire logic csrWrite,
  input wire logic [31:0] csrWdata,
  output logic csrRdValid,
  output logic [31:0] csrRdata,
  // Interrupt lines and mode from the rest of the core.
  input wire logic swIrq,
  input wire logic timerIrq,
  input wire logic extIrq,
  input wire logic [1:0] vecMode,
  // Best local-controller candidate.
  input wire logic localIrqValid,
  input wire logic [9:0] localIrqId,
  input wire logic [3:0] localIrqLevel,
  // Trap entry from the pipeline.
  input wire logic trapTaken,
  input wire logic trapIsIrq,
  input wire logic [9:0] trapCode,
  input wire logic [3:0] trapLevel,
  // Machine status value and its update from the next handler access.
  input wire logic [31:0] machStatus,
  output logic machStatusWr,
  output logic [31:0] machStatusData,
  // Vector table fetch.
  output logic vecFetchReq,
  output logic [31:0] vecFetchAddr,
  input wire logic vecFetchDone,
  input wire logic vecFetchErr,
  input wire logic [31:0] vecFetchData,
  // Program counter load after vectoring.
  output logic pcLoad,
  output logic [31:0] pcValue
);
  // Whole block state, registered in one place.
  typedef struct packed {
    logic irq;
    logic hwVec;
    logic [3:0] savedLvl;
    logic [9:0] code;
    logic [25:0] vbase;
    logic [3:0] lvl;
    tcirq_pkg::tcirq_vec_e vst;
    logic fetchReq;
    logic [31:0] fetchAddr;
    logic pcLoad;
    logic [31:0] pcVal;
    logic rdValid;
    logic [31:0] rdata;
    logic mstWr;
    logic [31:0] mstData;
  } tcirq_state_s;

  tcirq_state_s st_r; // Registered state.
  tcirq_state_s st_nxt; // Next state.
  logic rstSync_n; // Synchronised reset.
  logic localMode; // Local-controller mode in effect.
  logic offer; // Next handler has an interrupt to offer.
  logic [31:0] tableBase; // Vector table base as a byte address.
  logic [31:0] nextPtr; // Pointer that a next handler read returns.
  logic [31:0] reasonRd; // Trap reason as read.
  logic [31:0] pendRd; // Pending flags as read.
  logic [31:0] regRd; // Addressed register as read.
  logic [31:0] rmwOld; // Old value fed to the merge.
  logic [31:0] rmwNew; // Merged value.
  logic doWrite; // Access carries a write effect.

  // Local mode test is used for pending, reason and next handler decisions.
  function automatic logic isLocal(input logic [1:0] mode);
    isLocal = (mode == `TCIRQ_MODE_LDIRECT) || (mode == `TCIRQ_MODE_LVECTOR);
  endfunction

  // Legal codes; a written reserved code is kept out of the register.
  function automatic logic isLegalCode(input logic irq, input logic [9:0] code);
    if (irq) begin
      isLegalCode = (code == 10'(`TCIRQ_PEND_SW)) || (code == 10'(`TCIRQ_PEND_TIMER)) ||
        (code == 10'(`TCIRQ_PEND_EXT)) || (code == `TCIRQ_IRQ_LSW) ||
        ((code >= `TCIRQ_IRQ_LOCAL_LO) && (code <= `TCIRQ_IRQ_LOCAL_HI));
    end else begin
      isLegalCode = (code <= `TCIRQ_EXC_UCALL) || (code == `TCIRQ_EXC_MCALL);
    end
  endfunction

  tcirq_rst_sync u_rst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rstSync_n(rstSync_n)
  );

  // The merge serves reason, vector base and the status update of the next handler.
  tcirq_csr_rmw u_rmw (
    .op(csrOp),
    .operand(csrWdata),
    .oldValue(rmwOld),
    .newValue(rmwNew)
  );

  // Read views and the next handler decision.
  always_comb begin
    localMode = isLocal(vecMode);
    tableBase = {st_r.vbase, 6'h00};
    offer = localMode && localIrqValid && (localIrqLevel > st_r.savedLvl);
    nextPtr = offer ? (tableBase + {20'h00000, localIrqId, 2'b00}) : 32'h00000000;
    pendRd = 32'h00000000;
    if (!localMode) begin
      pendRd[`TCIRQ_PEND_SW] = swIrq;
      pendRd[`TCIRQ_PEND_TIMER] = timerIrq;
      pendRd[`TCIRQ_PEND_EXT] = extIrq;
    end
    reasonRd = 32'h00000000;
    reasonRd[`TCIRQ_RSN_IRQ] = st_r.irq;
    reasonRd[`TCIRQ_RSN_CODE_HI:0] = st_r.code;
    if (localMode) begin
      // Enable and privilege mirror the machine status, so they cannot disagree.
      reasonRd[`TCIRQ_RSN_HWV] = st_r.hwVec;
      reasonRd[`TCIRQ_RSN_PRIV_HI:`TCIRQ_RSN_PRIV_LO] =
        machStatus[`TCIRQ_MST_PRIV_HI:`TCIRQ_MST_PRIV_LO];
      reasonRd[`TCIRQ_RSN_LVL_HI:`TCIRQ_RSN_LVL_LO] = st_r.savedLvl;
      reasonRd[`TCIRQ_RSN_PIE] = machStatus[`TCIRQ_MST_PIE];
    end
    unique case (csrAddr)
      `TCIRQ_ADDR_PEND: regRd = pendRd;
      `TCIRQ_ADDR_REASON: regRd = reasonRd;
      `TCIRQ_ADDR_VBASE: regRd = tableBase;
      `TCIRQ_ADDR_NEXT: regRd = nextPtr;
      `TCIRQ_ADDR_LVLST: regRd = {16'h0000, st_r.lvl, 12'h000};
      default: regRd = 32'h00000000;
    endcase
    // The next handler merges into machine status, not into its own read value.
    rmwOld = (csrAddr == `TCIRQ_ADDR_NEXT) ? machStatus : regRd;
    doWrite = csrValid && csrWrite && (csrOp != tcirq_pkg::CSR_OP_NONE);
  end

  // Next state: CSR access, trap entry, then vectoring, in rising priority.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = csrValid;
    st_nxt.rdata = csrValid ? regRd : 32'h00000000;
    st_nxt.mstWr = 1'b0;
    st_nxt.pcLoad = 1'b0;
    if (doWrite) begin
      unique case (csrAddr)
        `TCIRQ_ADDR_REASON: begin
          // Reserved bits are dropped; mirrored fields live in machine status.
          st_nxt.irq = rmwNew[`TCIRQ_RSN_IRQ];
          if (isLegalCode(rmwNew[`TCIRQ_RSN_IRQ], rmwNew[`TCIRQ_RSN_CODE_HI:0])) begin
            st_nxt.code = rmwNew[`TCIRQ_RSN_CODE_HI:0];
          end
          if (localMode) begin
            st_nxt.savedLvl = rmwNew[`TCIRQ_RSN_LVL_HI:`TCIRQ_RSN_LVL_LO];
            st_nxt.hwVec = rmwNew[`TCIRQ_RSN_HWV];
          end
        end
        `TCIRQ_ADDR_VBASE: st_nxt.vbase = rmwNew[31:`TCIRQ_VBASE_LO];
        `TCIRQ_ADDR_NEXT: begin
          st_nxt.mstWr = 1'b1;
          st_nxt.mstData = rmwNew;
          if (offer) begin
            st_nxt.code = localIrqId;
            st_nxt.irq = 1'b1;
            st_nxt.lvl = localIrqLevel;
          end
        end
        default: begin
          // Pending and level status ignore writes.
          st_nxt.mstWr = 1'b0;
        end
      endcase
    end
    if (trapTaken) begin
      // A trap overrides the cause, interrupt bit and status write of a same-cycle CSR write; a vector base write still lands.
      st_nxt.irq = trapIsIrq;
      st_nxt.code = trapCode;
      st_nxt.mstWr = 1'b0;
      if (localMode) begin
        st_nxt.savedLvl = st_r.lvl;
      end
      if (trapIsIrq) begin
        st_nxt.lvl = trapLevel;
      end
      if (trapIsIrq && (vecMode == `TCIRQ_MODE_LVECTOR)) begin
        st_nxt.hwVec = 1'b1;
        st_nxt.vst = tcirq_pkg::VEC_FETCH;
        st_nxt.fetchReq = 1'b1;
        st_nxt.fetchAddr = tableBase + {20'h00000, trapCode, 2'b00};
      end
    end
    unique case (st_r.vst)
      tcirq_pkg::VEC_IDLE: begin
        // No table fetch is outstanding, so nothing waits here.
      end
      tcirq_pkg::VEC_FETCH: begin
        if (vecFetchDone) begin
          // Hardware clear of the flag wins over a software write in the same cycle.
          st_nxt.pcVal = {vecFetchData[31:1], 1'b0};
          st_nxt.pcLoad = 1'b1;
          st_nxt.hwVec = 1'b0;
          st_nxt.fetchReq = 1'b0;
          st_nxt.vst = tcirq_pkg::VEC_IDLE;
        end else if (vecFetchErr) begin
          // Flag stays set so the fault handler can resume the vectoring.
          st_nxt.fetchReq = 1'b0;
          st_nxt.vst = tcirq_pkg::VEC_IDLE;
        end
      end
    endcase
  end

  // Single state register.
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Registered outputs.
  assign csrRdValid = st_r.rdValid;
  assign csrRdata = st_r.rdata;
  assign machStatusWr = st_r.mstWr;
  assign machStatusData = st_r.mstData;
  assign vecFetchReq = st_r.fetchReq;
  assign vecFetchAddr = st_r.fetchAddr;
  assign pcLoad = st_r.pcLoad;
  assign pcValue = st_r.pcVal;

  // Pending reads zero whenever a local mode is selected.
  a_pend_local_zero: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_PEND) && isLocal(vecMode)) |=>
      (csrRdValid && (csrRdata == 32'h00000000)))
    else $error("pending read not zero in local mode");

  // Interrupt trap sets the top bit and keeps the number.
  a_trap_irq_code: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (trapTaken && trapIsIrq) |=> (st_r.irq && (st_r.code == $past(trapCode))))
    else $error("interrupt trap reason wrong");

  // Exception trap clears the top bit.
  a_trap_exc_bit: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (trapTaken && !trapIsIrq) |=> !st_r.irq)
    else $error("exception trap left interrupt bit set");

  // Vectored trap raises the flag and fetches the right entry.
  a_vec_fetch_addr: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (trapTaken && trapIsIrq && (vecMode == `TCIRQ_MODE_LVECTOR)) |=>
      (st_r.hwVec && vecFetchReq &&
       (vecFetchAddr == ({$past(st_r.vbase), 6'h00} + {20'h00000, $past(trapCode), 2'b00}))))
    else $error("vector fetch address or flag wrong");

  // Completed fetch loads an even address and drops the flag.
  a_vec_done_clear: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    ((st_r.vst == tcirq_pkg::VEC_FETCH) && vecFetchDone && !trapTaken) |=>
      (pcLoad && !st_r.hwVec && (pcValue == {$past(vecFetchData[31:1]), 1'b0})))
    else $error("vector completion wrong");

  // Vector base always reads aligned.
  a_vbase_aligned: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_VBASE)) |=> (csrRdata[5:0] == 6'h00))
    else $error("vector base read not aligned");

  // Nothing to offer means a zero read.
  a_next_none_zero: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_NEXT) && !offer) |=> (csrRdata == 32'h00000000))
    else $error("next handler read not zero");

  // A pure read of the next handler changes no state.
  a_next_read_only: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_NEXT) && !csrWrite && !trapTaken) |=>
      ($stable(st_r.code) && $stable(st_r.lvl) && $stable(st_r.irq) && !machStatusWr))
    else $error("next handler read changed state");

  // Level status reads the active level in its field.
  a_level_status: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_LVLST)) |=>
      (csrRdata == {16'h0000, $past(st_r.lvl), 12'h000}))
    else $error("level status read wrong");

  // Outside the local modes the pending read shows the three lines in place.
  a_pend_flag_map: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_PEND) && !isLocal(vecMode)) |=>
      (csrRdata == {20'h00000, $past(extIrq), 3'h0, $past(timerIrq), 3'h0,
                    $past(swIrq), 3'h0}))
    else $error("pending flags misplaced");

  // Reserved reason bits always read zero.
  a_reason_reserved: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_REASON)) |=> (csrRdata[22:10] == 13'h0000))
    else $error("reserved reason bits not zero");

  // The saved context and vectoring fields exist only in the local modes.
  a_reason_plain: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && (csrAddr == `TCIRQ_ADDR_REASON) && !isLocal(vecMode)) |=>
      (csrRdata[`TCIRQ_RSN_HWV:`TCIRQ_RSN_PIE] == 8'h00))
    else $error("local context fields visible outside local mode");

  // A set on the next handler merges its operand into the machine status.
  a_next_status_set: assert property (
    @(posedge sys_clk) disable iff (!rstSync_n)
    (csrValid && csrWrite && (csrOp == tcirq_pkg::CSR_OP_SET) &&
     (csrAddr == `TCIRQ_ADDR_NEXT) && !trapTaken) |=>
      (machStatusWr && (machStatusData == ($past(machStatus) | $past(csrWdata)))))
    else $error("next handler status update wrong");
endmodule

// File: tcirq_csr_test.sv
// Self-checking testbench for the trap reason and interrupt status CSR block.
`timescale 1ns/1ns
`include "tcirq_defines.svh"
module tcirq_csr_test;
  // One expected CSR answer, queued by the driver and taken by the monitor.
  typedef struct packed {
    logic chk;
    logic [31:0] rd;
    logic msWr;
    logic [31:0] msData;
  } tcirq_note_s;
  // Stimulus, every input is given a value at time zero.
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic csrValid = 1'b0;
  logic [11:0] csrAddr = 12'h000;
  tcirq_pkg::tcirq_op_e csrOp = tcirq_pkg::CSR_OP_NONE;
  logic csrWrite = 1'b0;
  logic [31:0] csrWdata = 32'h0;
  logic swIrq = 1'b0, timerIrq = 1'b0, extIrq = 1'b0;
  logic [1:0] vecMode = 2'h0;
  logic localIrqValid = 1'b0;
  logic [9:0] localIrqId = 10'h000;
  logic [3:0] localIrqLevel = 4'h0;
  logic trapTaken = 1'b0, trapIsIrq = 1'b0;
  logic [9:0] trapCode = 10'h000;
  logic [3:0] trapLevel = 4'h0;
  logic [31:0] machStatus = 32'h0;
  logic vecFetchDone = 1'b0, vecFetchErr = 1'b0;
  logic [31:0] vecFetchData = 32'h0;
  // Outputs of the block.
  logic csrRdValid, machStatusWr, vecFetchReq, pcLoad;
  logic [31:0] csrRdata, machStatusData, vecFetchAddr, pcValue;
  // Reference model state, predicted from the stimulus alone.
  logic [31:0] vb = 32'h0;
  logic [9:0] rCode = 10'h000;
  logic rIrq = 1'b0, hwv = 1'b0;
  logic [3:0] act = 4'h0, saved = 4'h0;
  logic [31:0] d, ptr;
  tcirq_note_s notes[$];
  tcirq_note_s got;
  int fails = 0;
  int nTests = 0;

  tcirq_csr i_dut (.sys_clk, .rst_n, .csrValid, .csrAddr, .csrOp, .csrWrite, .csrWdata,
    .csrRdValid, .csrRdata, .swIrq, .timerIrq, .extIrq, .vecMode, .localIrqValid,
    .localIrqId, .localIrqLevel, .trapTaken, .trapIsIrq, .trapCode, .trapLevel, .machStatus,
    .machStatusWr, .machStatusData, .vecFetchReq, .vecFetchAddr, .vecFetchDone, .vecFetchErr,
    .vecFetchData, .pcLoad, .pcValue);

  // The 10 MHz core clock.
  always #50 sys_clk = ~sys_clk;

  // Expected trap reason; the extra context fields only exist in the local modes.
  function automatic logic [31:0] rsnExp();
    rsnExp = {rIrq, 21'h0, rCode};
    if (vecMode[1]) begin
      rsnExp[30:23] = {hwv, machStatus[12:11], saved, machStatus[7]};
    end
  endfunction

  // Compares one value and counts it.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One CSR access; the expected answer is queued before the request is taken.
  task automatic csr(input logic [11:0] a, input tcirq_pkg::tcirq_op_e op, input logic wr,
      input logic [31:0] wd, input logic chk, input logic [31:0] exp, input logic mw = 1'b0);
    notes.push_back('{chk, exp, mw, machStatus | wd});
    @(posedge sys_clk);
    csrValid <= 1'b1;
    csrAddr <= a;
    csrOp <= op;
    csrWrite <= wr;
    csrWdata <= wd;
    @(posedge sys_clk);
    csrValid <= 1'b0;
  endtask

  // A plain read behaves like a set with a zero operand and no write effect.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    csr(a, tcirq_pkg::CSR_OP_SET, 1'b0, 32'h0, 1'b1, exp);
  endtask

  // Trap entry pulse; the reason records whatever code the pipeline hands over.
  task automatic trap(input logic irq, input logic [9:0] c, input logic [3:0] lvl);
    @(posedge sys_clk);
    trapTaken <= 1'b1;
    trapIsIrq <= irq;
    trapCode <= c;
    trapLevel <= lvl;
    @(posedge sys_clk);
    trapTaken <= 1'b0;
    rIrq = irq;
    rCode = c;
    if (vecMode[1]) begin
      saved = act;
    end
    if (irq) begin
      act = lvl;
    end
    if (irq && vecMode == 2'h3) begin
      hwv = 1'b1;
    end
  endtask

  // Monitor: each answer pulse takes the oldest note; looked at mid-cycle when settled.
  always @(negedge sys_clk) begin
    if (csrRdValid === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpectedAnswer", 32'h1, 32'h0);
      end else begin
        got = notes.pop_front();
        if (got.chk) check("csrRdata", csrRdata, got.rd);
        check("machStatusWr", {31'h0, machStatusWr}, {31'h0, got.msWr});
        if (got.msWr) check("machStatusData", machStatusData, got.msData);
      end
    end
  end

  // Watchdog so that a hang still reaches the closing report.
  initial begin
    #2000000;
    fails++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    void'($urandom(86));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    // Reset values, and an unmapped address that reads zero.
    rd(`TCIRQ_ADDR_REASON, 32'h0);
    rd(`TCIRQ_ADDR_LVLST, 32'h0);
    rd(`TCIRQ_ADDR_VBASE, 32'h0);
    rd(12'h300, 32'h0);
    // Pending flags in every mode; a write to them must be ignored.
    for (int m = 0; m < 4; m++) begin
      d = $urandom;
      vecMode <= 2'(m);
      {extIrq, timerIrq, swIrq} <= d[2:0];
      csr(`TCIRQ_ADDR_PEND, tcirq_pkg::CSR_OP_WRITE, 1'b1, 32'hffffffff, 1'b0, 32'h0);
      rd(`TCIRQ_ADDR_PEND, m >= 2 ? 32'h0 : {20'h0, d[2], 3'h0, d[1], 3'h0, d[0], 3'h0});
    end
    // All three merge kinds on the vector base; the low six bits always read zero.
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      csr(`TCIRQ_ADDR_VBASE, tcirq_pkg::tcirq_op_e'(k % 3 + 1), 1'b1, d, 1'b0, 32'h0);
      vb = (k % 3 == 0) ? d : (k % 3 == 1) ? (vb | d) : (vb & ~d);
      vb[5:0] = 6'h0;
      rd(`TCIRQ_ADDR_VBASE, vb);
    end
    // Every low code as exception and as interrupt, reserved ones included.
    vecMode <= 2'h0;
    for (int c = 0; c < 16; c++) begin
      trap(1'b0, 10'(c), 4'h0);
      rd(`TCIRQ_ADDR_REASON, rsnExp());
      trap(1'b1, 10'(c), 4'h0);
      rd(`TCIRQ_ADDR_REASON, rsnExp());
    end
    // Software writes of reserved codes are refused; legal ones land.
    csr(`TCIRQ_ADDR_REASON, tcirq_pkg::CSR_OP_WRITE, 1'b1, 32'h0000000d, 1'b0, 32'h0);
    rIrq = 1'b0;
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    csr(`TCIRQ_ADDR_REASON, tcirq_pkg::CSR_OP_WRITE, 1'b1, 32'h80000010, 1'b0, 32'h0);
    rIrq = 1'b1;
    rCode = 10'h010;
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    // Local direct mode: saved context fields and the active level.
    vecMode <= 2'h2;
    machStatus <= $urandom;
    trap(1'b1, 10'h00c, 4'h5);
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    trap(1'b1, 10'h08f, 4'h9);
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    rd(`TCIRQ_ADDR_LVLST, {16'h0, act, 12'h0});
    // Local vectored mode: table fetch, then the handler address goes to the pc.
    vecMode <= 2'h3;
    trap(1'b1, 10'h014, 4'hc);
    @(negedge sys_clk);
    check("vecFetchReq", {31'h0, vecFetchReq}, 32'h1);
    check("vecFetchAddr", vecFetchAddr, vb + 32'd80);
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    d = $urandom | 32'h1;
    vecFetchDone <= 1'b1;
    vecFetchData <= d;
    @(posedge sys_clk);
    vecFetchDone <= 1'b0;
    @(negedge sys_clk);
    check("pcLoad", {31'h0, pcLoad}, 32'h1);
    check("pcValue", pcValue, d & 32'hfffffffe);
    check("vecFetchReqDone", {31'h0, vecFetchReq}, 32'h0);
    hwv = 1'b0;
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    // Next handler: level equal to the saved one is refused, one above is offered.
    vecMode <= 2'h2;
    localIrqValid <= 1'b1;
    localIrqId <= 10'h01e;
    localIrqLevel <= 4'h9;
    ptr = vb + 32'd120;
    rd(`TCIRQ_ADDR_NEXT, 32'h0);
    localIrqLevel <= 4'ha;
    rd(`TCIRQ_ADDR_NEXT, ptr);
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    rd(`TCIRQ_ADDR_LVLST, {16'h0, act, 12'h0});
    csr(`TCIRQ_ADDR_NEXT, tcirq_pkg::CSR_OP_SET, 1'b1, 32'h8, 1'b1, ptr, 1'b1);
    rIrq = 1'b1;
    rCode = 10'h01e;
    act = 4'ha;
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    rd(`TCIRQ_ADDR_LVLST, {16'h0, act, 12'h0});
    localIrqValid <= 1'b0;
    rd(`TCIRQ_ADDR_NEXT, 32'h0);
    // A failed table fetch drops the request but leaves vectoring flagged.
    vecMode <= 2'h3;
    trap(1'b1, 10'h010, 4'hd);
    vecFetchErr <= 1'b1;
    @(posedge sys_clk);
    vecFetchErr <= 1'b0;
    @(negedge sys_clk);
    check("vecFetchReqErr", {31'h0, vecFetchReq}, 32'h0);
    check("pcLoadErr", {31'h0, pcLoad}, 32'h0);
    rd(`TCIRQ_ADDR_REASON, rsnExp());
    repeat (3) @(posedge sys_clk);
    check("answersLeft", 32'(notes.size()), 32'h0);
    end_of_test();
  end
endmodule
